//--- logic/msc_pkg.sv
`default_nettype none

package msc_pkg;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int          MSC_ADDR_W   = 12;
    localparam int          MSC_DATA_W   = 32;
    localparam logic [11:0] MSC_OFF_LOW  = 12'h000;
    localparam logic [11:0] MSC_OFF_MID  = 12'h004;
    localparam logic [11:0] MSC_OFF_HIGH = 12'h008;
    localparam logic [11:0] MSC_OFF_CTRL = 12'h00c;

    // ------------------------------------------------------------------
    // control field positions and reset values
    // ------------------------------------------------------------------
    localparam int          MSC_CTRL_MODE_BIT  = 0;
    localparam int          MSC_CTRL_DEC_BIT   = 4;
    localparam int          MSC_CTRL_ENC_BIT   = 5;
    localparam int          MSC_CTRL_READY_BIT = 7;
    localparam logic [7:0]  MSC_DATA_RST       = 8'h00;
    localparam logic        MSC_BIT_RST        = 1'b0;

    // ------------------------------------------------------------------
    // manchester symbol pairs
    // ------------------------------------------------------------------
    localparam logic [1:0]  MSC_SYM_ZERO = 2'h2;
    localparam logic [1:0]  MSC_SYM_ONE  = 2'h1;

    // ------------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } msc_apb_req_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] mid;
        logic [7:0] low;
    } msc_data_t;

    typedef enum logic {
        msc_st_idle,
        msc_st_ack
    } msc_apb_state_t;

endpackage

`default_nettype wire

//--- logic/msc_nibble_encoder.sv
`timescale 1ns/1ps
`default_nettype none

// each input bit becomes one symbol pair, msb pair first
module msc_nibble_encoder #(
    parameter int BITS = 8
) (
    input  wire logic [BITS-1:0]   byte_in,
    output logic      [2*BITS-1:0] code_out
);

    genvar i;
    generate
        for (i = 0; i < BITS; i++) begin : g_bit
            assign code_out[2*i+1:2*i] = byte_in[i] ? msc_pkg::MSC_SYM_ONE
                                                     : msc_pkg::MSC_SYM_ZERO;
        end
    endgenerate

endmodule // msc_nibble_encoder

`default_nettype wire

//--- logic/msc_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none

// two-cycle access phase: pready rises one cycle into access
module msc_apb_slave (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic [11:0]             paddr,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    input  wire logic [31:0]             rd_word,
    input  wire logic                    addr_hit,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output msc_pkg::msc_apb_req_t        req,
    output logic                         commit
);

    msc_pkg::msc_apb_state_t state_reg;
    msc_pkg::msc_apb_state_t state_next;
    logic [31:0]             prdata_next;
    logic                    pslverr_next;

    wire access = psel & penable;

    assign req.addr  = paddr;
    assign req.write = pwrite;
    assign req.wdata = pwdata;
    assign commit    = access & pready;

    always_comb begin
        state_next   = state_reg;
        prdata_next  = prdata;
        pslverr_next = pslverr;
        case (state_reg)
            msc_pkg::msc_st_idle: begin
                if (access) begin
                    state_next   = msc_pkg::msc_st_ack;
                    prdata_next  = pwrite ? 32'h0000_0000 : rd_word;
                    pslverr_next = ~addr_hit;
                end
            end
            msc_pkg::msc_st_ack: begin
                state_next   = msc_pkg::msc_st_idle;
                prdata_next  = 32'h0000_0000;
                pslverr_next = 1'b0;
            end
            default: begin
                state_next = msc_pkg::msc_st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= msc_pkg::msc_st_idle;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else begin
            state_reg <= state_next;
            prdata    <= prdata_next;
            pslverr   <= pslverr_next;
        end
    end

    assign pready = (state_reg == msc_pkg::msc_st_ack);

endmodule // msc_apb_slave

`default_nettype wire

//--- logic/msc_codec.sv
// Summary of operation
// - three byte data registers plus control register
// - manchester encode consumes exactly one byte
// - encode yields two bytes of output
// - data right justified; high byte untouched
// - source byte in low; start bit launches
// - upper nibble code to mid, lower to low
// - source readable until start; result replaces
// - encode and decode start bits self clear
// - ready sticky until software writes zero
// - one control write clears ready and starts
// - zero bit gives 10, one gives 01
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module msc_codec (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [11:0] paddr,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    msc_pkg::msc_data_t    data_reg;
    msc_pkg::msc_data_t    data_next;
    logic                  mode_reg;
    logic                  mode_next;
    logic                  enc_go_reg;
    logic                  enc_go_next;
    logic                  dec_go_reg;
    logic                  dec_go_next;
    logic                  ready_reg;
    logic                  ready_next;

    msc_pkg::msc_apb_req_t req;
    logic                  commit;
    logic [31:0]           rd_word;
    logic [15:0]           enc_code;
    logic [7:0]            ctrl_byte;
    logic                  hit_any;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    msc_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .paddr    (paddr),
        .pwrite   (pwrite),
        .pwdata   (pwdata),
        .rd_word  (rd_word),
        .addr_hit (hit_any),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .req      (req),
        .commit   (commit)
    );

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hit_low  = (req.addr == msc_pkg::MSC_OFF_LOW);
    wire hit_mid  = (req.addr == msc_pkg::MSC_OFF_MID);
    wire hit_high = (req.addr == msc_pkg::MSC_OFF_HIGH);
    wire hit_ctrl = (req.addr == msc_pkg::MSC_OFF_CTRL);
    assign hit_any = hit_low | hit_mid | hit_high | hit_ctrl;

    wire wr_commit = commit & req.write;
    wire low_wr    = wr_commit & hit_low;
    wire mid_wr    = wr_commit & hit_mid;
    wire high_wr   = wr_commit & hit_high;
    wire ctrl_wr   = wr_commit & hit_ctrl;

    wire wr_mode  = req.wdata[msc_pkg::MSC_CTRL_MODE_BIT];
    wire wr_dec   = req.wdata[msc_pkg::MSC_CTRL_DEC_BIT];
    wire wr_enc   = req.wdata[msc_pkg::MSC_CTRL_ENC_BIT];
    wire wr_ready = req.wdata[msc_pkg::MSC_CTRL_READY_BIT];

    // ------------------------------------------------------------------
    // encoder
    // ------------------------------------------------------------------
    // with mode one the three of six path owns the data, not this one
    wire enc_fire = enc_go_reg & ~mode_reg;

    msc_nibble_encoder #(
        .BITS (8)
    ) u_enc (
        .byte_in  (data_reg.low),
        .code_out (enc_code)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        data_next = data_reg;
        if (low_wr) begin
            data_next.low = req.wdata[7:0];
        end
        if (mid_wr) begin
            data_next.mid = req.wdata[7:0];
        end
        if (high_wr) begin
            data_next.high = req.wdata[7:0];
        end
        // conversion wins over a data write in the same cycle
        if (enc_fire) begin
            data_next.mid = enc_code[15:8];
            data_next.low = enc_code[7:0];
        end
    end

    assign mode_next   = ctrl_wr ? wr_mode : mode_reg;
    assign enc_go_next = ctrl_wr & wr_enc;
    assign dec_go_next = ctrl_wr & wr_dec;
    // hardware set wins over a clearing write in the same cycle
    assign ready_next  = enc_fire
                       | (ready_reg & ~(ctrl_wr & ~wr_ready));

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg.low  <= msc_pkg::MSC_DATA_RST;
            data_reg.mid  <= msc_pkg::MSC_DATA_RST;
            data_reg.high <= msc_pkg::MSC_DATA_RST;
            mode_reg      <= msc_pkg::MSC_BIT_RST;
            enc_go_reg    <= msc_pkg::MSC_BIT_RST;
            dec_go_reg    <= msc_pkg::MSC_BIT_RST;
            ready_reg     <= msc_pkg::MSC_BIT_RST;
        end else begin
            data_reg   <= data_next;
            mode_reg   <= mode_next;
            enc_go_reg <= enc_go_next;
            dec_go_reg <= dec_go_next;
            ready_reg  <= ready_next;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[msc_pkg::MSC_CTRL_MODE_BIT]  = mode_reg;
        ctrl_byte[msc_pkg::MSC_CTRL_DEC_BIT]   = dec_go_reg;
        ctrl_byte[msc_pkg::MSC_CTRL_ENC_BIT]   = enc_go_reg;
        ctrl_byte[msc_pkg::MSC_CTRL_READY_BIT] = ready_reg;
    end

    assign rd_word = hit_low  ? {24'h00_0000, data_reg.low}  :
                     hit_mid  ? {24'h00_0000, data_reg.mid}  :
                     hit_high ? {24'h00_0000, data_reg.high} :
                     hit_ctrl ? {24'h00_0000, ctrl_byte}     :
                                32'h0000_0000;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence start_enc_s;
        ctrl_wr && wr_enc && !wr_mode && !wr_ready && !enc_go_reg;
    endsequence

    sequence finish_enc_s;
        enc_go_reg && !mode_reg ##1 ready_reg && !enc_go_reg;
    endsequence

    // reference pairs built straight from the source bits, not the encoder
    wire [7:0] src_byte     = data_reg.low;
    wire [7:0] exp_mid_code = {~src_byte[7], src_byte[7], ~src_byte[6],
                               src_byte[6], ~src_byte[5], src_byte[5],
                               ~src_byte[4], src_byte[4]};
    wire [7:0] exp_low_code = {~src_byte[3], src_byte[3], ~src_byte[2],
                               src_byte[2], ~src_byte[1], src_byte[1],
                               ~src_byte[0], src_byte[0]};
    wire [7:0] wr_low_byte  = req.wdata[7:0];
    wire       mid_src      = mid_wr | enc_fire;

    enc_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_enc_s |=> finish_enc_s)
        else $error("encode start did not end in ready");

    clr_and_go_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_enc_s |=> !ready_reg ##1 ready_reg)
        else $error("combined control write misbehaved");

    enc_selfclr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_go_reg |=> !enc_go_reg)
        else $error("encode start bit did not self clear");

    dec_selfclr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(dec_go_reg) |=> !dec_go_reg [*2])
        else $error("decode start bit did not self clear");

    ready_sticky_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ready_reg && !(ctrl_wr && !wr_ready) |=> ready_reg)
        else $error("ready flag dropped without software clear");

    ready_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr && !wr_ready && !enc_fire |=> !ready_reg)
        else $error("ready flag ignored software clear");

    mid_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_fire |=> data_reg.mid == $past(exp_mid_code)
                     && data_reg.low == $past(exp_low_code))
        else $error("encoded nibbles in wrong registers");

    zero_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_fire && data_reg.low == 8'h0f
        |=> data_reg.mid == 8'haa && data_reg.low == 8'h55)
        else $error("manchester symbol table wrong");

    high_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_fire && !high_wr |=> $stable(data_reg.high))
        else $error("encode disturbed the high register");

    src_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enc_fire && !low_wr |=> $stable(data_reg.low))
        else $error("source byte changed before start");

    mode_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_go_reg && mode_reg && !low_wr |=> $stable(data_reg.low))
        else $error("manchester path ran in three of six mode");

    unmapped_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !hit_any |=> pready && pslverr)
        else $error("unmapped access not flagged");

    pready_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready stood longer than one cycle");

    rd_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data shown outside an answer");

    err_pair_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag raised without pready");

    rd_upper_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    ready_noset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr && wr_ready && !ready_reg && !enc_fire |=> !ready_reg)
        else $error("software write set the ready flag");

    mode_noready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enc_go_reg && mode_reg && !ready_reg |=> !ready_reg)
        else $error("ready set in three of six mode");

    mode_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> mode_reg == $past(wr_mode))
        else $error("mode bit not taken from bit 0");

    go_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> enc_go_reg == $past(wr_enc)
                    && dec_go_reg == $past(wr_dec))
        else $error("start bits not taken from bits 5 and 4");

    low_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        low_wr && !enc_fire |=> data_reg.low == $past(wr_low_byte))
        else $error("source byte not loaded into low register");

    mid_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(data_reg.mid) |-> $past(mid_src))
        else $error("middle register changed without cause");

endmodule // msc_codec

`default_nettype wire

//--- bench/msc_apb_master.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// apb master standing in for the processor core
// ----------------------------------------------------------------------
module msc_apb_master (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic      [11:0] paddr,
    output logic             pwrite,
    output logic      [31:0] pwdata
);
    logic hung;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        paddr = 12'h000;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // released lines show the inverse so stale values never match
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung = (n >= 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwrite <= ~w;
        pwdata <= ~d;
    endtask
endmodule // msc_apb_master

`default_nettype wire

//--- bench/msc_codec_test.sv
`timescale 1ns/1ps
`default_nettype none

module msc_codec_test;
    localparam logic [11:0] LOW  = msc_pkg::MSC_OFF_LOW;
    localparam logic [11:0] MID  = msc_pkg::MSC_OFF_MID;
    localparam logic [11:0] HIGH = msc_pkg::MSC_OFF_HIGH;
    localparam logic [11:0] CTRL = msc_pkg::MSC_OFF_CTRL;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel;
    logic        penable;
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          mismatches = 0;
    int          comparisons = 0;

    always #4 pclk = ~pclk;

    msc_codec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .paddr(paddr), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    msc_apb_master master_u (.pclk(pclk), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .paddr(paddr), .pwrite(pwrite),
        .pwdata(pwdata));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] man(input logic [3:0] n);
        logic [7:0] r;
        for (int i = 0; i < 4; i++) r[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
        return r;
    endfunction

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic e_exp,
                       output logic [31:0] q);
        logic e;
        master_u.xfer(a, w, d, q, e);
        if (master_u.hung === 1'b1) begin
            mismatches++;
            $display("CHECK FAILED pready expected 1 seen 0");
            stop_test();
        end
        check("pslverr", {31'h0000_0000, e_exp}, {31'h0000_0000, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        acc(a, 1'b1, {24'h00_0000, d}, 1'b0, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x,
                      input string what);
        logic [31:0] q;
        acc(a, 1'b0, 32'h0000_0000, 1'b0, q);
        check(what, {24'h00_0000, x}, q);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic sc_zero;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 8'h00, "reset");
    endtask

    task automatic sc_encode(input logic [7:0] b);
        wr(CTRL, 8'h00);
        wr(HIGH, 8'h3c);
        wr(MID, 8'hc3);
        wr(LOW, b);
        rd(LOW, b, "source");
        wr(CTRL, 8'h20);
        rd(CTRL, 8'h80, "ctrl done");
        rd(MID, man(b[7:4]), "mid");
        rd(LOW, man(b[3:0]), "low");
        rd(HIGH, 8'h3c, "high");
    endtask

    task automatic sc_sticky;
        repeat (20) @(posedge pclk);
        rd(CTRL, 8'h80, "ready held");
        wr(CTRL, 8'h80);
        rd(CTRL, 8'h80, "ready one");
        wr(CTRL, 8'h20);
        rd(CTRL, 8'h80, "clear and go");
        rd(MID, man(4'ha), "again mid");
        rd(LOW, man(4'ha), "again low");
        wr(CTRL, 8'h10);
        rd(CTRL, 8'h00, "ready clear");
    endtask

    task automatic sc_mode;
        wr(LOW, 8'h3c);
        wr(CTRL, 8'h21);
        rd(CTRL, 8'h01, "mode ctrl");
        rd(LOW, 8'h3c, "mode low");
        wr(CTRL, 8'h80);
        rd(CTRL, 8'h00, "ready write one");
    endtask

    task automatic sc_unmapped;
        logic [31:0] q;
        acc(12'h010, 1'b1, 32'h0000_00ff, 1'b1, q);
        acc(12'h010, 1'b0, 32'h0000_0000, 1'b1, q);
        check("unmapped read", 32'h0000_0000, q);
        acc(12'hffc, 1'b0, 32'h0000_0000, 1'b1, q);
        check("far unmapped read", 32'h0000_0000, q);
        rd(LOW, 8'h3c, "alias");
    endtask

    task automatic sc_reset_again;
        wr(CTRL, 8'h01);
        wr(LOW, 8'ha5);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        sc_zero();
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        sc_zero();
        for (int i = 0; i < 16; i++) sc_encode({i[3:0], ~i[3:0]});
        sc_sticky();
        sc_mode();
        sc_unmapped();
        sc_reset_again();
        stop_test();
    end
endmodule // msc_codec_test

`default_nettype wire
